// *** rtl/dlbc_top.sv ***
// lock tracking, sleep/float control and self-test logic of six channels
//
// Contract
// - two consecutive missed embedded clock edges raise lock loss, resync.
// - sleep low stops channel lock and floats every output.
// - leaving sleep restarts initialization; system waits for it.
// - output enable low floats data and recovered clock outputs.
// - output enable high again resumes the prior state untouched.
// - boundary-scan test ignores sleep and output enable pins.
// - self-test runs about 33 ms at the system clock.
// - 12-bit result, complete and pass per channel, channel 6 on top.
// - pass only when bit-error rate is better than one in 10^7.
// - leaving test-logic-reset powers link circuits, overriding sleep.
// - captured sleep value during scan test is always 1.
// - standalone test runs without scan port, others keep traffic.
// - activate must hold a level 4 cycles to switch test.
// - test runs until deactivated; lock loss low, data reports errors.
// - gross mode: any error holds all ten outputs high.
// - bit mode: only outputs of errored bits go high.
// - select 0..5 one channel, 6 all, 7 idle.
// - outputs float after power-up until a channel locks.
// - lock loss high until locked; low means data valid.
// - data and clock outputs float while lock loss is high.
`timescale 1ns/1ps
`include "dlbc_regs.svh"
module dlbc_top #(
  parameter int unsigned SELFTEST_CYC = `DLBC_SELFTEST_CYC
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic local_reference_clock,
  input wire logic [71:0] rx_word,
  input wire logic [5:0] rx_valid,
  input wire logic sleep_ctrl_n,
  input wire logic out_drive_en,
  input wire logic tap_test_logic_reset,
  input wire logic selftest_instruction,
  input wire logic scan_out_en,
  input wire logic standalone_test_activate,
  input wire logic standalone_channel_select_0,
  input wire logic standalone_channel_select_1,
  input wire logic standalone_channel_select_2,
  input wire logic error_report_select,
  output logic [59:0] rout,
  output logic [5:0] rout_oe,
  output logic [5:0] rclk,
  output logic [5:0] rclk_oe,
  output logic [5:0] lock_loss_n,
  output logic [5:0] lock_oe,
  output logic [11:0] selftest_result_chain,
  output logic sleep_capture
);

  // ----------------------------------------------------------------------
  // decoding
  // ----------------------------------------------------------------------
  function automatic logic chan_under(input logic act, input logic [2:0] sel,
                                      input int ch);
    chan_under = act && sel != `DLBC_SEL_IDLE &&
                 (sel == `DLBC_SEL_ALL || sel == 3'(ch));
  endfunction

  // ----------------------------------------------------------------------
  // core domain: power, scan override and self-test sequencing
  // ----------------------------------------------------------------------
  dlbc_pkg::dlbc_core_t c_r;
  dlbc_pkg::dlbc_core_t c_nxt;
  dlbc_pkg::dlbc_lnk_t q_r;
  dlbc_pkg::dlbc_lnk_t q_nxt;

  always_comb begin
    logic tlr;
    logic run;
    tlr = 1'b0;
    run = 1'b0;
    c_nxt = c_r;
    c_nxt.sy1 = {scan_out_en, out_drive_en, sleep_ctrl_n,
                 selftest_instruction, tap_test_logic_reset};
    c_nxt.sy2 = c_r.sy1;
    c_nxt.ps1 = q_r.st_pass;
    c_nxt.ps2 = c_r.ps1;
    tlr = c_r.sy2[`DLBC_CS_TLR];
    run = c_r.sy2[`DLBC_CS_RUN];
    // out of test-logic-reset the sleep pin loses all say
    c_nxt.awake = tlr ? c_r.sy2[`DLBC_CS_SLEEP] : 1'b1;
    c_nxt.en = tlr ? c_r.sy2[`DLBC_CS_EN]
                   : c_r.sy2[`DLBC_CS_SCAN_EN];
    c_nxt.cap_sleep = tlr ? c_r.sy2[`DLBC_CS_SLEEP] : 1'b1;
    unique case (c_r.st)
      dlbc_pkg::ST_IDLE: begin
        if (run && !tlr) begin
          c_nxt.st = dlbc_pkg::ST_RUN;
          c_nxt.tmr = 32'h0;
          c_nxt.st_act = 1'b1;
          c_nxt.res = `DLBC_RES_RESET;
        end
      end
      dlbc_pkg::ST_RUN: begin
        c_nxt.tmr = c_r.tmr + 32'h1;
        if (tlr) begin
          c_nxt.st = dlbc_pkg::ST_IDLE;
          c_nxt.st_act = 1'b0;
        end else if (c_r.tmr == 32'(SELFTEST_CYC - 1)) begin
          c_nxt.st = dlbc_pkg::ST_SETTLE;
          c_nxt.st_act = 1'b0;
          c_nxt.stl = 6'h0;
        end
      end
      dlbc_pkg::ST_SETTLE: begin
        // link side keeps counting a few words until the stop crosses
        c_nxt.stl = c_r.stl + 6'h1;
        if (c_r.stl == `DLBC_SETTLE_CYC - 6'h1) begin
          c_nxt.st = dlbc_pkg::ST_DONE;
          for (int i = 0; i < `DLBC_NCH; i++) begin
            c_nxt.res[2*i + `DLBC_RES_DONE_BIT] = 1'b1;
            c_nxt.res[2*i + `DLBC_RES_PASS_BIT] = c_r.ps2[i];
          end
        end
      end
      dlbc_pkg::ST_DONE: begin
        if (!run || tlr) begin
          c_nxt.st = dlbc_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      c_r <= '0;
    end else begin
      c_r <= c_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // link domain: lock, standalone error test and output control
  // ----------------------------------------------------------------------
  always_comb begin
    logic [11:0] w;
    logic [9:0] err;
    logic edge_ok;
    logic under;
    logic awake;
    logic en;
    logic st;
    w = 12'h000;
    err = 10'h000;
    edge_ok = 1'b0;
    under = 1'b0;
    awake = 1'b0;
    en = 1'b0;
    st = 1'b0;
    q_nxt = q_r;
    q_nxt.sy1 = {c_r.st_act, c_r.en, c_r.awake, error_report_select,
                 standalone_channel_select_2, standalone_channel_select_1,
                 standalone_channel_select_0, standalone_test_activate};
    q_nxt.sy2 = q_r.sy1;
    awake = q_r.sy2[`DLBC_LS_AWAKE];
    en = q_r.sy2[`DLBC_LS_EN];
    st = q_r.sy2[`DLBC_LS_ST];
    q_nxt.st_d = st;
    // level must differ from the active state four samples running
    if (q_r.sy2[`DLBC_LS_ACT] != q_r.act_q) begin
      if (q_r.act_cnt == `DLBC_ACT_QUAL - 3'h1) begin
        q_nxt.act_q = q_r.sy2[`DLBC_LS_ACT];
        q_nxt.act_cnt = 3'h0;
      end else begin
        q_nxt.act_cnt = q_r.act_cnt + 3'h1;
      end
    end else begin
      q_nxt.act_cnt = 3'h0;
    end
    for (int i = 0; i < `DLBC_NCH; i++) begin
      w = rx_word[`DLBC_WORD_W*i +: `DLBC_WORD_W];
      edge_ok = w[`DLBC_START_BIT] && !w[`DLBC_STOP_BIT];
      err = w[10:`DLBC_DATA_LSB] ^ (q_r.prev[i] + 10'h001);
      under = chan_under(q_r.act_q, q_r.sy2[`DLBC_LS_SEL +: 3], i);
      if (!awake) begin
        // a sleeping channel drops lock and re-initialises on wake
        q_nxt.locked[i] = 1'b0;
        q_nxt.miss[i] = 1'b0;
        q_nxt.good[i] = 7'h00;
      end else if (rx_valid[i]) begin
        q_nxt.prev[i] = w[10:`DLBC_DATA_LSB];
        if (q_r.locked[i]) begin
          q_nxt.miss[i] = !edge_ok;
          if (!edge_ok && q_r.miss[i]) begin
            q_nxt.locked[i] = 1'b0;
            q_nxt.good[i] = 7'h00;
          end
        end else if (edge_ok) begin
          q_nxt.good[i] = q_r.good[i] + 7'h01;
          if (q_r.good[i] == `DLBC_LOCK_WORDS - 7'h01) begin
            q_nxt.locked[i] = 1'b1;
            q_nxt.miss[i] = 1'b0;
          end
        end else begin
          q_nxt.good[i] = 7'h00;
        end
      end
      if (!under) begin
        q_nxt.stick[i] = 1'b0;
        q_nxt.errb[i] = 10'h000;
      end else if (rx_valid[i] && q_r.locked[i]) begin
        q_nxt.errb[i] = err;
        if (err != 10'h000) begin
          q_nxt.stick[i] = 1'b1;
        end
      end
      if (st && !q_r.st_d) begin
        q_nxt.st_err[i] = 8'h00;
        q_nxt.st_bits[i] = 32'h0;
      end else if (st && rx_valid[i] && q_r.locked[i]) begin
        q_nxt.st_bits[i] = q_r.st_bits[i] + 32'h0000000A;
        if (err != 10'h000 && q_r.st_err[i] != 8'hFF) begin
          q_nxt.st_err[i] = q_r.st_err[i] + 8'h01;
        end
      end
      q_nxt.st_pass[i] = 64'(q_r.st_bits[i]) >
                         64'(q_r.st_err[i]) * `DLBC_BER_DEN;
      if (under) begin
        q_nxt.rout[10*i +: 10] = q_r.sy2[`DLBC_LS_REP] ? q_nxt.errb[i]
                                 : {10{q_nxt.stick[i]}};
      end else if (rx_valid[i] && q_r.locked[i]) begin
        q_nxt.rout[10*i +: 10] = w[10:`DLBC_DATA_LSB];
      end
      q_nxt.rclk[i] = rx_valid[i] && q_nxt.locked[i];
      q_nxt.lock_n[i] = under ? 1'b0 : !q_nxt.locked[i];
      q_nxt.lock_oe[i] = awake;
      // lock state is kept while floated, so re-enable resumes it
      q_nxt.rout_oe[i] = awake && en &&
                         (q_nxt.locked[i] || under);
      q_nxt.rclk_oe[i] = awake && en && q_nxt.locked[i];
    end
  end

  always_ff @(posedge local_reference_clock or negedge arst_n) begin
    if (!arst_n) begin
      q_r <= '0;
      q_r.lock_n <= 6'h3F;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign rout = q_r.rout;
  assign rout_oe = q_r.rout_oe;
  assign rclk = q_r.rclk;
  assign rclk_oe = q_r.rclk_oe;
  assign lock_loss_n = q_r.lock_n;
  assign lock_oe = q_r.lock_oe;
  assign selftest_result_chain = c_r.res;
  assign sleep_capture = c_r.cap_sleep;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  logic under0;
  assign under0 = chan_under(q_r.act_q, q_r.sy2[`DLBC_LS_SEL +: 3], 0);

  property p_lock_loss;
    @(posedge local_reference_clock) disable iff (!arst_n)
      q_r.locked[0] && q_r.miss[0] && rx_valid[0] && !rx_word[11] &&
      q_r.sy2[`DLBC_LS_AWAKE] && !under0 |=> lock_loss_n[0] && !rout_oe[0];
  endproperty
  a_lock_loss: assert property (p_lock_loss)
    else $error("lock loss not raised after two missed edges");

  property p_sleep_float;
    @(posedge local_reference_clock) disable iff (!arst_n)
      !q_r.sy2[`DLBC_LS_AWAKE] |=> lock_oe == 6'h00 && rout_oe == 6'h00 &&
      rclk_oe == 6'h00;
  endproperty
  a_sleep_float: assert property (p_sleep_float)
    else $error("outputs driven while asleep");

  property p_en_float;
    @(posedge local_reference_clock) disable iff (!arst_n)
      !q_r.sy2[`DLBC_LS_EN] |=> rout_oe == 6'h00 && rclk_oe == 6'h00;
  endproperty
  a_en_float: assert property (p_en_float)
    else $error("outputs driven with enable low");

  property p_float_unlocked;
    @(posedge local_reference_clock) disable iff (!arst_n)
      lock_loss_n[0] |-> !rout_oe[0] && !rclk_oe[0];
  endproperty
  a_float_unlocked: assert property (p_float_unlocked)
    else $error("channel driven while lock lost");

  property p_act_qual;
    @(posedge local_reference_clock) disable iff (!arst_n)
      $rose(q_r.act_q) |-> $past(q_r.sy2[0], 1) && $past(q_r.sy2[0], 2) &&
      $past(q_r.sy2[0], 3) && $past(q_r.sy2[0], 4);
  endproperty
  a_act_qual: assert property (p_act_qual)
    else $error("standalone test started without four stable samples");

  // every channel checked, since the bench drives errors on several
  generate
    for (genvar g = 0; g < `DLBC_NCH; g++) begin : g_report
      property p_gross;
        @(posedge local_reference_clock) disable iff (!arst_n)
          q_r.stick[g] && !q_r.sy2[`DLBC_LS_REP] &&
          chan_under(q_r.act_q, q_r.sy2[`DLBC_LS_SEL +: 3], g)
          |=> rout[10*g +: 10] == 10'h3FF && !lock_loss_n[g];
      endproperty
      a_gross: assert property (p_gross)
        else $error("gross error report not held high");

      property p_bit_clean;
        @(posedge local_reference_clock) disable iff (!arst_n)
          q_r.sy2[`DLBC_LS_REP] && q_r.locked[g] && rx_valid[g] &&
          chan_under(q_r.act_q, q_r.sy2[`DLBC_LS_SEL +: 3], g) &&
          rx_word[`DLBC_WORD_W*g + `DLBC_DATA_LSB +: 10] ==
          q_r.prev[g] + 10'h001
          |=> rout[10*g +: 10] == 10'h000;
      endproperty
      a_bit_clean: assert property (p_bit_clean)
        else $error("bit error report raised without an error");
    end
  endgenerate

  property p_idle_sel;
    @(posedge local_reference_clock) disable iff (!arst_n)
      q_r.act_q && q_r.sy2[`DLBC_LS_SEL +: 3] == `DLBC_SEL_IDLE &&
      q_r.sy2[`DLBC_LS_AWAKE] && q_r.locked == 6'h3F && q_r.miss == 6'h00
      |=> lock_loss_n == 6'h00 && q_r.stick == 6'h00;
  endproperty
  a_idle_sel: assert property (p_idle_sel)
    else $error("idle select code put a channel under test");

  property p_wake_init;
    @(posedge local_reference_clock) disable iff (!arst_n)
      $rose(q_r.sy2[`DLBC_LS_AWAKE]) |-> q_r.locked == 6'h00 &&
      rout_oe == 6'h00;
  endproperty
  a_wake_init: assert property (p_wake_init)
    else $error("channel kept lock across sleep");

  property p_scan_capture;
    @(posedge core_clk) disable iff (!arst_n)
      !c_r.sy2[`DLBC_CS_TLR] |=> sleep_capture && c_r.awake;
  endproperty
  a_scan_capture: assert property (p_scan_capture)
    else $error("sleep not overridden out of test-logic-reset");

  property p_result;
    @(posedge core_clk) disable iff (!arst_n)
      c_r.st == dlbc_pkg::ST_SETTLE && c_r.stl == `DLBC_SETTLE_CYC - 6'h1
      |=> selftest_result_chain[11] && selftest_result_chain[1] &&
      selftest_result_chain[0] == $past(c_r.ps2[0]);
  endproperty
  a_result: assert property (p_result)
    else $error("self-test result not reported");

  property p_run_len;
    @(posedge core_clk) disable iff (!arst_n)
      $fell(c_r.st_act) && c_r.st == dlbc_pkg::ST_SETTLE
      |-> $past(c_r.tmr) == 32'(SELFTEST_CYC - 1);
  endproperty
  a_run_len: assert property (p_run_len)
    else $error("self-test ran the wrong length");

  c_lock_lost: cover property (@(posedge local_reference_clock)
    disable iff (!arst_n) $rose(lock_loss_n[0]));
  c_standalone: cover property (@(posedge local_reference_clock)
    disable iff (!arst_n) $rose(q_r.act_q));
  c_selftest_done: cover property (@(posedge core_clk)
    disable iff (!arst_n) c_r.st == dlbc_pkg::ST_DONE);

endmodule // dlbc_top

// *** rtl/dlbc_regs.svh ***
// constants of the deserializer lock, power and self-test control block
`ifndef DLBC_REGS_SVH
`define DLBC_REGS_SVH

// ----------------------------------------------------------------------
// channel and word layout
// ----------------------------------------------------------------------
`define DLBC_NCH 6
`define DLBC_WORD_W 12
`define DLBC_START_BIT 11
`define DLBC_STOP_BIT 0
`define DLBC_DATA_LSB 1

// ----------------------------------------------------------------------
// link-side synchroniser bit positions
// ----------------------------------------------------------------------
`define DLBC_LS_ACT 0
`define DLBC_LS_SEL 1
`define DLBC_LS_REP 4
`define DLBC_LS_AWAKE 5
`define DLBC_LS_EN 6
`define DLBC_LS_ST 7

// ----------------------------------------------------------------------
// core-side synchroniser bit positions
// ----------------------------------------------------------------------
`define DLBC_CS_TLR 0
`define DLBC_CS_RUN 1
`define DLBC_CS_SLEEP 2
`define DLBC_CS_EN 3
`define DLBC_CS_SCAN_EN 4

// ----------------------------------------------------------------------
// selection codes and result layout
// ----------------------------------------------------------------------
`define DLBC_SEL_ALL 3'h6
`define DLBC_SEL_IDLE 3'h7
`define DLBC_RES_PASS_BIT 0
`define DLBC_RES_DONE_BIT 1
`define DLBC_RES_RESET 12'h000

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define DLBC_ACT_QUAL 3'h4
`define DLBC_LOCK_WORDS 7'h50
`define DLBC_BER_DEN 64'h0000000000989680
`define DLBC_SETTLE_CYC 6'h20
`define DLBC_SELFTEST_MS 33
`define DLBC_CORE_MHZ 100
`define DLBC_SELFTEST_CYC (`DLBC_SELFTEST_MS * `DLBC_CORE_MHZ * 1000)

`endif

// *** rtl/dlbc_pkg.sv ***
// types of the deserializer lock, power and self-test control block
`include "dlbc_regs.svh"
package dlbc_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_SETTLE, ST_DONE} dlbc_st_t;

  typedef struct packed {
    logic [7:0] sy1;
    logic [7:0] sy2;
    logic act_q;
    logic [2:0] act_cnt;
    logic st_d;
    logic [5:0] locked;
    logic [5:0] miss;
    logic [5:0] stick;
    logic [5:0] st_pass;
    logic [5:0][6:0] good;
    logic [5:0][9:0] prev;
    logic [5:0][9:0] errb;
    logic [5:0][7:0] st_err;
    logic [5:0][31:0] st_bits;
    logic [59:0] rout;
    logic [5:0] rout_oe;
    logic [5:0] rclk;
    logic [5:0] rclk_oe;
    logic [5:0] lock_n;
    logic [5:0] lock_oe;
  } dlbc_lnk_t;

  typedef struct packed {
    logic [4:0] sy1;
    logic [4:0] sy2;
    logic [5:0] ps1;
    logic [5:0] ps2;
    dlbc_st_t st;
    logic [31:0] tmr;
    logic [5:0] stl;
    logic [11:0] res;
    logic awake;
    logic en;
    logic st_act;
    logic cap_sleep;
  } dlbc_core_t;

endpackage

// *** testbench/dlbc_ser_model.sv ***
// far-side serializer model: framed incrementing words on every channel
`timescale 1ns/1ps
module dlbc_ser_model (
  input wire logic lclk,
  input wire logic arst_n,
  input wire logic [5:0] bad,
  input wire logic [5:0] flip,
  input wire logic [9:0] flip_mask,
  output logic [71:0] rx_word,
  output logic [5:0] rx_valid
);
  logic [5:0][9:0] cnt;

  // ----------------------------------------------------------------------
  // word source
  // ----------------------------------------------------------------------
  // sync patterns and traffic share the incrementing source, so a relock
  // request needs no separate path
  always_ff @(posedge lclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 6; i++) begin
        cnt[i] <= 10'(i * 10'h097);
      end
      rx_word <= 72'h0;
      rx_valid <= 6'h00;
    end else begin
      rx_valid <= 6'h3F;
      for (int i = 0; i < 6; i++) begin
        cnt[i] <= cnt[i] + 10'h001;
        // start high, stop low; bad drops the start bit
        rx_word[12*i +: 12] <= {~bad[i], cnt[i] ^ (flip[i] ? flip_mask
                                : 10'h000), 1'b0};
      end
    end
  end
endmodule // dlbc_ser_model

// *** testbench/tb_top.sv ***
// self-checking bench of the lock, sleep and self-test control block
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic lclk = 1'b0;
  logic arst_n = 1'b0;
  logic sleep_n = 1'b1;
  logic den = 1'b1;
  logic tlr = 1'b1;
  logic inst = 1'b0;
  logic sen = 1'b0;
  logic act = 1'b0;
  logic [2:0] sel = 3'h0;
  logic rep = 1'b0;
  logic [5:0] bad = 6'h00;
  logic [5:0] flip = 6'h00;
  logic [71:0] rx_word;
  logic [5:0] rx_valid;
  logic [59:0] rout;
  logic [5:0] rout_oe, rclk, rclk_oe, lock_loss_n, lock_oe;
  logic [11:0] res;
  logic sleep_capture;
  logic hit;
  int n_mismatch = 0;
  int comparisons = 0;

  always #5 core_clk = ~core_clk;
  always #16 lclk = ~lclk;

  dlbc_ser_model ser_u (.lclk(lclk), .arst_n(arst_n), .bad(bad),
    .flip(flip), .flip_mask(10'h010), .rx_word(rx_word),
    .rx_valid(rx_valid));

  // short self-test run keeps the bench fast
  dlbc_top #(.SELFTEST_CYC(200)) dut_u (.core_clk(core_clk),
    .arst_n(arst_n), .local_reference_clock(lclk), .rx_word(rx_word),
    .rx_valid(rx_valid), .sleep_ctrl_n(sleep_n), .out_drive_en(den),
    .tap_test_logic_reset(tlr), .selftest_instruction(inst),
    .scan_out_en(sen), .standalone_test_activate(act),
    .standalone_channel_select_0(sel[0]),
    .standalone_channel_select_1(sel[1]),
    .standalone_channel_select_2(sel[2]),
    .error_report_select(rep), .rout(rout), .rout_oe(rout_oe),
    .rclk(rclk), .rclk_oe(rclk_oe), .lock_loss_n(lock_loss_n),
    .lock_oe(lock_oe), .selftest_result_chain(res),
    .sleep_capture(sleep_capture));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic lw(input int n);
    repeat (n) @(posedge lclk);
    #1;
  endtask

  task automatic inj_bad(input int ch, input int n);
    lw(1);
    bad[ch] = 1'b1;
    lw(n);
    bad[ch] = 1'b0;
  endtask

  task automatic inj_flip(input int ch);
    lw(1);
    flip[ch] = 1'b1;
    lw(1);
    flip[ch] = 1'b0;
  endtask

  // held all-ones across two words means a gross error report
  task automatic stuck(input int ch, input logic exp);
    logic [9:0] v;
    v = rout[10*ch +: 10];
    lw(1);
    chk("gross_hold", 16'(exp), 16'(v == 10'h3FF &&
        rout[10*ch +: 10] == 10'h3FF));
  endtask

  // neighbours keep live traffic: each word one above the last
  task automatic live(input int ch);
    logic [9:0] v;
    v = rout[10*ch +: 10];
    lw(1);
    chk("live", 16'(v + 10'h001), 16'(rout[10*ch +: 10]));
  endtask

  task automatic conclude;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    #1 arst_n = 1'b1;
    lw(60);
    chk("lock_early", 16'h003F, 16'(lock_loss_n));
    chk("oe_early", 16'h0000, 16'(rout_oe));
    lw(50);
    chk("lock", 16'h0000, 16'(lock_loss_n));
    chk("oe_lock", 16'h003F, 16'(rout_oe));
    chk("rclk", 16'h003F, 16'(rclk));
    chk("rclk_oe", 16'h003F, 16'(rclk_oe));
    inj_bad(0, 1);
    lw(4);
    chk("one_miss", 16'h0000, 16'(lock_loss_n));
    inj_bad(0, 2);
    lw(3);
    chk("two_miss", 16'h0001, 16'(lock_loss_n));
    chk("oe_lost", 16'h003E, 16'(rout_oe));
    lw(90);
    chk("relock", 16'h0000, 16'(lock_loss_n));
    den = 1'b0;
    lw(12);
    chk("float_d", 16'h0000, 16'({rout_oe, rclk_oe}));
    chk("lock_oe_on", 16'h003F, 16'(lock_oe));
    den = 1'b1;
    lw(12);
    chk("resume", 16'h003F, 16'({lock_loss_n, rout_oe}));
    sleep_n = 1'b0;
    lw(12);
    chk("sleep", 16'h0000, 16'({rout_oe, lock_oe}));
    sleep_n = 1'b1;
    lw(30);
    chk("wake_init", 16'h003F, 16'(lock_loss_n));
    lw(90);
    chk("wake_lock", 16'h0000, 16'(lock_loss_n));
    // gross report on one channel, neighbours untouched
    sel = 3'h2;
    act = 1'b1;
    lw(12);
    inj_flip(2);
    lw(4);
    stuck(2, 1'b1);
    lw(6);
    stuck(2, 1'b1);
    stuck(1, 1'b0);
    live(1);
    chk("bert_lock", 16'h003F, 16'({lock_loss_n, rout_oe}));
    act = 1'b0;
    lw(12);
    stuck(2, 1'b0);
    // two-cycle activate pulse must not qualify
    sel = 3'h6;
    act = 1'b1;
    lw(2);
    act = 1'b0;
    lw(12);
    inj_flip(4);
    lw(4);
    stuck(4, 1'b0);
    // per-bit report on all channels
    rep = 1'b1;
    act = 1'b1;
    lw(12);
    hit = 1'b0;
    inj_flip(3);
    for (int k = 0; k < 5; k++) begin
      if (rout[39:30] == 10'h010) hit = 1'b1;
      lw(1);
    end
    chk("bit_mode", 16'h0001, 16'(hit));
    stuck(3, 1'b0);
    act = 1'b0;
    lw(12);
    // idle select code
    sel = 3'h7;
    rep = 1'b0;
    act = 1'b1;
    lw(12);
    inj_flip(5);
    lw(4);
    stuck(5, 1'b0);
    act = 1'b0;
    lw(12);
    // scan mode forces power and ignores the sleep pin
    tlr = 1'b0;
    sen = 1'b1;
    sleep_n = 1'b0;
    den = 1'b0;
    lw(12);
    chk("cap_sleep", 16'h0001, 16'(sleep_capture));
    chk("forced_on", 16'h003F, 16'(rout_oe));
    inst = 1'b1;
    lw(20);
    inj_flip(0);
    for (int k = 0; k < 3000 && res[11] !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
    if (res[11] !== 1'b1) begin
      n_mismatch++;
      $display("BAD selftest_wait exp 1 got %b", res[11]);
    end
    lw(4);
    chk("selftest", 16'h0FFE, 16'(res));
    inst = 1'b0;
    tlr = 1'b1;
    sen = 1'b0;
    sleep_n = 1'b1;
    den = 1'b1;
    lw(4);
    conclude();
  end
endmodule // tb_top
